/* logic/pkes_defs.svh */
`ifndef PKES_DEFS_SVH
`define PKES_DEFS_SVH

// ==========================================================
// Register map
`define PKES_ADDR_STATUS     32'h5000_600C
`define PKES_ADDR_VERSION    32'h5000_6010
`define PKES_ADDR_LAUNCH     32'h5000_6014
`define PKES_STATUS_RESET    32'h0000_0000
`define PKES_FW_RESET        8'h00
`define PKES_HW_REV_DEFAULT  8'h01
`define PKES_WORD_ZERO       32'h0000_0000

// ==========================================================
// Status fields
`define PKES_BIT_BUSY        16
`define PKES_BIT_PRIME       12
`define PKES_BIT_NOINV       11
`define PKES_BIT_COEFF       10
`define PKES_BIT_SIG         9
`define PKES_BIT_ORDER       7
`define PKES_BIT_COORD       6
`define PKES_BIT_INF         5
`define PKES_BIT_OFFC        4
`define PKES_FAIL_HI         3
`define PKES_FAIL_LO         0

// ==========================================================
// Version and launch fields
`define PKES_HW_HI           15
`define PKES_HW_LO           8
`define PKES_FW_HI           7
`define PKES_FW_LO           0
`define PKES_LAUNCH_BIT      0
`define PKES_OPC_HI          14
`define PKES_OPC_LO          8

// ==========================================================
// Operation codes
`define PKES_GRP_ARITH       3'h0
`define PKES_GRP_POINT       3'h2
`define PKES_GRP_HIGH        3'h3
`define PKES_OPC_INV_ODD     4'h6
`define PKES_OPC_INV_EVEN    4'h9
`define PKES_OPC_PRIMALITY   7'h0E
`define PKES_OPC_CURVE_COEFF_CHECK_CMD    7'h23
`define PKES_OPC_ON_CURVE    7'h24
`define PKES_OPC_CHECK_N     7'h25
`define PKES_OPC_COUPLE      7'h26
`define PKES_SIG_PREFIX      5'h0D

`endif

/* logic/pkes_pkg.sv */
package pkes_pkg;
    typedef enum logic {
        PKES_IDLE,
        PKES_RUN
    } pkes_state_type;

    typedef logic [6:0] pkes_opcode_type;
endpackage

/* logic/pkes_reg_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface pkes_reg_if;
    logic        wr_en;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        hit;

    modport slave (output wr_en, output addr, output wdata, input rdata, input hit);
    modport bank  (input wr_en, input addr, input wdata, output rdata, output hit);
endinterface
`default_nettype wire

/* logic/pkes_flag.sv */
`timescale 1ns/1ps
`default_nettype none
module pkes_flag #(
    parameter int W = 1
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         upd,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    // Holds its last result until the next matching command ends
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else if (upd) begin
            q <= d;
        end
    end
endmodule
`default_nettype wire

/* logic/pkes_apb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pkes_defs.svh"
module pkes_apb (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    pkes_reg_if.slave        bus
);
    logic acc_first;

    // ==========================================================
    // One wait state: ready comes in the second access cycle
    assign acc_first = psel && penable && !pready;
    assign bus.addr  = paddr;
    assign bus.wdata = pwdata;
    // Write lands only on the edge that completes the transfer
    assign bus.wr_en = psel && penable && pready && pwrite && bus.hit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= `PKES_WORD_ZERO;
        end else begin
            pready  <= acc_first;
            pslverr <= acc_first && !bus.hit;
            if (acc_first && !pwrite && bus.hit) begin
                prdata <= bus.rdata;
            end else begin
                prdata <= `PKES_WORD_ZERO;
            end
        end
    end

    // ==========================================================
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_apb_one_wait: assert property (acc_first |=> pready ##1 !pready)
        else $error("Ready not one cycle after access");
    chk_apb_unmapped_err: assert property (acc_first && !bus.hit |=> pslverr && prdata == 0)
        else $error("Unmapped access not refused");
endmodule
`default_nettype wire

/* logic/pkes_top.sv */
// Operation
// - Busy is high while a computation runs and falls when it completes.
// - A primality test reports 0 for probably prime and 1 for composite.
// - An arithmetic-group inversion (code 0x06 or 0x09) with no inverse sets the no-inverse flag.
// - The coefficient check sets its flag when the discriminant is zero.
// - Any signature command updates the reject flag, 1 meaning reject.
// - The order check updates its flag, 1 meaning the order is invalid.
// - The coordinate check updates its flag, 1 meaning the pair is not below the prime.
// - Every curve operation updates the infinity flag.
// - The on-curve check updates its flag, 1 meaning the point is off the curve.
// - The fail address holds the last point that was off curve, invalid or at infinity.
// - The version register shows hardware revision and firmware revision.
// - The engine overwrites the firmware revision, so software reads it first.
// - A launch while busy is ignored and the launch bit clears at completion.
`timescale 1ns/1ps
`default_nettype none
`include "pkes_defs.svh"
module pkes_top #(
    // Arbitrary value, not tied to any real part
    parameter logic [7:0] HW_REVISION = `PKES_HW_REV_DEFAULT
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        op_done,
    input  wire logic        res_composite,
    input  wire logic        res_no_inverse,
    input  wire logic        res_coeff_bad,
    input  wire logic        res_sig_reject,
    input  wire logic        res_order_bad,
    input  wire logic        res_coord_bad,
    input  wire logic        res_at_infinity,
    input  wire logic        res_off_curve,
    input  wire logic [3:0]  res_fail_addr,
    input  wire logic        fw_rev_we,
    input  wire logic [7:0]  fw_rev_data,
    output logic             launch_pulse,
    output logic      [6:0]  operation_code_field,
    output logic             busy
);
    pkes_reg_if bus ();

    pkes_pkg::pkes_state_type state_q;
    pkes_pkg::pkes_opcode_type opc_q;
    logic                      operation_launch_bit_q;
    logic [7:0]                firmware_revision_q;
    logic                      launch_wr;
    logic                      launch_ok;
    logic                      finish;
    logic                      is_inv;
    logic                      is_prime;
    logic                      is_ab;
    logic                      is_oncurve;
    logic                      is_order;
    logic                      is_couple;
    logic                      is_point;
    logic                      is_sig;
    logic [7:0]                flag_upd;
    logic [7:0]                flag_val;
    logic [7:0]                flag_q;
    logic                      fail_upd;
    logic [3:0]                fail_addr_q;
    logic [31:0]               status_word;
    logic [31:0]               version_word;
    logic [31:0]               launch_word;

    // ==========================================================
    // Register bus
    pkes_apb u_apb (
        .pclk    (pclk),
        .presetn (presetn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .bus     (bus.slave)
    );

    assign bus.hit = (bus.addr == `PKES_ADDR_STATUS) || (bus.addr == `PKES_ADDR_VERSION)
                  || (bus.addr == `PKES_ADDR_LAUNCH);

    always_comb begin
        status_word                                 = `PKES_STATUS_RESET;
        status_word[`PKES_BIT_BUSY]                 = busy;
        status_word[`PKES_BIT_PRIME]                = flag_q[7];
        status_word[`PKES_BIT_NOINV]                = flag_q[6];
        status_word[`PKES_BIT_COEFF]                = flag_q[5];
        status_word[`PKES_BIT_SIG]                  = flag_q[4];
        status_word[`PKES_BIT_ORDER]                = flag_q[3];
        status_word[`PKES_BIT_COORD]                = flag_q[2];
        status_word[`PKES_BIT_INF]                  = flag_q[1];
        status_word[`PKES_BIT_OFFC]                 = flag_q[0];
        status_word[`PKES_FAIL_HI:`PKES_FAIL_LO]    = fail_addr_q;
        version_word                                = `PKES_WORD_ZERO;
        version_word[`PKES_HW_HI:`PKES_HW_LO]       = HW_REVISION;
        version_word[`PKES_FW_HI:`PKES_FW_LO]       = firmware_revision_q;
        launch_word                                 = `PKES_WORD_ZERO;
        launch_word[`PKES_OPC_HI:`PKES_OPC_LO]      = opc_q;
        launch_word[`PKES_LAUNCH_BIT]               = operation_launch_bit_q;
    end

    always_comb begin
        case (bus.addr)
            `PKES_ADDR_STATUS:  bus.rdata = status_word;
            `PKES_ADDR_VERSION: bus.rdata = version_word;
            `PKES_ADDR_LAUNCH:  bus.rdata = launch_word;
            default:            bus.rdata = `PKES_WORD_ZERO;
        endcase
    end

    // ==========================================================
    // Launch control
    assign launch_wr = bus.wr_en && (bus.addr == `PKES_ADDR_LAUNCH);
    assign launch_ok = launch_wr && (state_q == pkes_pkg::PKES_IDLE)
                    && bus.wdata[`PKES_LAUNCH_BIT];
    assign finish    = op_done && (state_q == pkes_pkg::PKES_RUN);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= pkes_pkg::PKES_IDLE;
        end else begin
            case (state_q)
                pkes_pkg::PKES_IDLE: begin
                    if (launch_ok) begin
                        state_q <= pkes_pkg::PKES_RUN;
                    end
                end
                pkes_pkg::PKES_RUN: begin
                    if (op_done) begin
                        state_q <= pkes_pkg::PKES_IDLE;
                    end
                end
                default: state_q <= pkes_pkg::PKES_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            operation_launch_bit_q <= 1'b0;
            opc_q                  <= '0;
        end else if (finish) begin
            operation_launch_bit_q <= 1'b0;
        end else if (launch_wr && state_q == pkes_pkg::PKES_IDLE) begin
            // Code frozen while running so results classify correctly
            operation_launch_bit_q <= bus.wdata[`PKES_LAUNCH_BIT];
            opc_q                  <= bus.wdata[`PKES_OPC_HI:`PKES_OPC_LO];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            launch_pulse         <= 1'b0;
            operation_code_field <= '0;
            busy                 <= 1'b0;
        end else begin
            launch_pulse         <= launch_ok;
            busy                 <= launch_ok || (busy && !op_done);
            if (launch_ok) begin
                operation_code_field <= bus.wdata[`PKES_OPC_HI:`PKES_OPC_LO];
            end
        end
    end

    // ==========================================================
    // Command classes
    always_comb begin
        is_inv     = (opc_q[6:4] == `PKES_GRP_ARITH)
                  && ((opc_q[3:0] == `PKES_OPC_INV_ODD) || (opc_q[3:0] == `PKES_OPC_INV_EVEN));
        is_prime   = (opc_q == `PKES_OPC_PRIMALITY);
        is_ab      = (opc_q == `PKES_OPC_CURVE_COEFF_CHECK_CMD);
        is_oncurve = (opc_q == `PKES_OPC_ON_CURVE);
        is_order   = (opc_q == `PKES_OPC_CHECK_N);
        is_couple  = (opc_q == `PKES_OPC_COUPLE);
        is_point   = (opc_q[6:4] == `PKES_GRP_POINT) || (opc_q[6:4] == `PKES_GRP_HIGH);
        is_sig     = (opc_q[6:2] == `PKES_SIG_PREFIX);
    end

    // ==========================================================
    // Result flags
    always_comb begin
        flag_upd[0] = finish && is_oncurve;
        flag_val[0] = res_off_curve;
        flag_upd[1] = finish && is_point;
        flag_val[1] = res_at_infinity;
        flag_upd[2] = finish && is_couple;
        flag_val[2] = res_coord_bad;
        flag_upd[3] = finish && is_order;
        flag_val[3] = res_order_bad;
        flag_upd[4] = finish && is_sig;
        flag_val[4] = res_sig_reject;
        flag_upd[5] = finish && is_ab;
        flag_val[5] = res_coeff_bad;
        flag_upd[6] = finish && is_inv;
        flag_val[6] = res_no_inverse;
        flag_upd[7] = finish && is_prime;
        flag_val[7] = res_composite;
    end

    for (genvar i = 0; i < 8; i++) begin : g_flag
        pkes_flag #(.W(1)) u_flag (
            .pclk    (pclk),
            .presetn (presetn),
            .upd     (flag_upd[i]),
            .d       (flag_val[i]),
            .q       (flag_q[i])
        );
    end

    assign fail_upd = finish && is_point && (res_off_curve || res_coord_bad || res_at_infinity);

    pkes_flag #(.W(4)) u_fail (
        .pclk    (pclk),
        .presetn (presetn),
        .upd     (fail_upd),
        .d       (res_fail_addr),
        .q       (fail_addr_q)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            firmware_revision_q <= `PKES_FW_RESET;
        end else if (fw_rev_we) begin
            firmware_revision_q <= fw_rev_data;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence seq_launch;
        launch_ok;
    endsequence

    sequence seq_finish;
        finish;
    endsequence

    chk_busy_rise_launch: assert property (
        seq_launch |=> busy && launch_pulse ##1 !launch_pulse)
        else $error("Busy or launch pulse wrong after launch");
    chk_busy_fall_done: assert property (
        seq_finish |=> !busy && state_q == pkes_pkg::PKES_IDLE)
        else $error("Busy did not fall at completion");
    chk_prime_result: assert property (
        seq_finish ##0 is_prime |=> flag_q[7] == $past(res_composite))
        else $error("Primality outcome not reported");
    chk_noinv_flag: assert property (
        seq_finish ##0 is_inv |=> status_word[`PKES_BIT_NOINV] == $past(res_no_inverse))
        else $error("Inversion flag not updated");
    chk_coeff_flag: assert property (
        seq_finish ##0 is_ab |=> flag_q[5] == $past(res_coeff_bad))
        else $error("Coefficient flag not updated");
    chk_sig_flag: assert property (
        seq_finish ##0 is_sig |=> flag_q[4] == $past(res_sig_reject))
        else $error("Signature flag not updated");
    chk_order_flag: assert property (
        seq_finish ##0 is_order |=> flag_q[3] == $past(res_order_bad))
        else $error("Order flag not updated");
    chk_coord_flag: assert property (
        seq_finish ##0 is_couple |=> flag_q[2] == $past(res_coord_bad))
        else $error("Coordinate flag not updated");
    chk_inf_flag: assert property (
        !(finish && is_point) |=> $stable(flag_q[1]))
        else $error("Infinity flag moved without curve op");
    chk_inf_update: assert property (
        seq_finish ##0 is_point |=> flag_q[1] == $past(res_at_infinity))
        else $error("Infinity flag not updated");
    chk_offcurve_flag: assert property (
        seq_finish ##0 is_oncurve |=> flag_q[0] == $past(res_off_curve))
        else $error("On-curve flag not updated");
    chk_fail_addr_hold: assert property (
        fail_upd |=> fail_addr_q == $past(res_fail_addr))
        else $error("Fail address not captured");
    chk_version_hw: assert property (
        version_word[`PKES_HW_HI:`PKES_HW_LO] == HW_REVISION)
        else $error("Hardware revision field wrong");
    chk_fw_overwrite: assert property (
        fw_rev_we |=> firmware_revision_q == $past(fw_rev_data))
        else $error("Firmware field not overwritten");
    chk_launch_ignored: assert property (
        launch_wr && busy |=> !launch_pulse && $stable(opc_q))
        else $error("Launch while busy not ignored");
    chk_launch_autoclr: assert property (
        seq_finish |=> !operation_launch_bit_q)
        else $error("Launch bit not cleared at completion");
endmodule
`default_nettype wire

/* tb/pkes_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pkes_defs.svh"
module pkes_top_tb;
    // Arbitrary revision value, unrelated to any real part
    localparam logic [7:0] HW_REV = 8'h5A;

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        op_done;
    logic [7:0]  res;
    logic [3:0]  res_fail_addr;
    logic        fw_rev_we;
    logic [7:0]  fw_rev_data;
    logic        launch_pulse;
    logic [6:0]  operation_code_field;
    logic        busy;
    logic [31:0] exp_status;
    int          failures;
    int          checks_done;

    pkes_top #(.HW_REVISION(HW_REV)) dut (
        .pclk                 (pclk),
        .presetn              (presetn),
        .psel                 (psel),
        .penable              (penable),
        .pwrite               (pwrite),
        .paddr                (paddr),
        .pwdata               (pwdata),
        .prdata               (prdata),
        .pready               (pready),
        .pslverr              (pslverr),
        .op_done              (op_done),
        .res_composite        (res[7]),
        .res_no_inverse       (res[6]),
        .res_coeff_bad        (res[5]),
        .res_sig_reject       (res[4]),
        .res_order_bad        (res[3]),
        .res_coord_bad        (res[2]),
        .res_at_infinity      (res[1]),
        .res_off_curve        (res[0]),
        .res_fail_addr        (res_fail_addr),
        .fw_rev_we            (fw_rev_we),
        .fw_rev_data          (fw_rev_data),
        .launch_pulse         (launch_pulse),
        .operation_code_field (operation_code_field),
        .busy                 (busy)
    );

    // ==========================================================
    // Helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t ns: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic chk1(input logic seen, input logic exp, input string what);
        check({31'h0000_0000, seen}, {31'h0000_0000, exp}, what);
    endtask

    // Holds the request until pready is sampled high; the watchdog bounds the wait
    task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
                       output logic [31:0] rdata, output logic err);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wdata;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdata = prdata;
        err   = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [31:0] addr, input logic [31:0] exp, input logic exp_err);
        logic [31:0] d;
        logic        e;
        apb(1'b0, addr, 32'h0000_0000, d, e);
        check(d, exp, "read data");
        chk1(e, exp_err, "read error");
    endtask

    task automatic wr(input logic [31:0] addr, input logic [31:0] data, input logic exp_err);
        logic [31:0] d;
        logic        e;
        apb(1'b1, addr, data, d, e);
        chk1(e, exp_err, "write error");
    endtask

    // Completion pulse; results driven inverted after it so stale sampling shows
    task automatic finish(input logic [7:0] r, input logic [3:0] a);
        @(posedge pclk);
        op_done       <= 1'b1;
        res           <= r;
        res_fail_addr <= a;
        @(posedge pclk);
        op_done       <= 1'b0;
        res           <= ~r;
        res_fail_addr <= ~a;
        #1;
    endtask

    // ==========================================================
    // Expected status after a completion
    task automatic model(input logic [6:0] c, input logic [7:0] r, input logic [3:0] a);
        if (c == `PKES_OPC_PRIMALITY) exp_status[12] = r[7];
        if (c[6:4] == `PKES_GRP_ARITH && (c[3:0] == 4'h6 || c[3:0] == 4'h9))
            exp_status[11] = r[6];
        if (c == `PKES_OPC_CURVE_COEFF_CHECK_CMD) exp_status[10] = r[5];
        if (c[6:2] == `PKES_SIG_PREFIX) exp_status[9] = r[4];
        if (c == `PKES_OPC_CHECK_N) exp_status[7] = r[3];
        if (c == `PKES_OPC_COUPLE) exp_status[6] = r[2];
        if (c == `PKES_OPC_ON_CURVE) exp_status[4] = r[0];
        if (c[6:5] == 2'b01) begin
            exp_status[5] = r[1];
            if (r[0] | r[1] | r[2]) exp_status[3:0] = a;
        end
    endtask

    task automatic run_op(input logic [6:0] c, input logic [7:0] r, input logic [3:0] a);
        wr(`PKES_ADDR_LAUNCH, {17'h0_0000, c, 7'h00, 1'b1}, 1'b0);
        #1;
        chk1(launch_pulse, 1'b1, "launch pulse");
        chk1(busy, 1'b1, "busy high");
        check({25'h000_0000, operation_code_field}, {25'h000_0000, c}, "code");
        finish(r, a);
        chk1(busy, 1'b0, "busy low");
        chk1(launch_pulse, 1'b0, "pulse ended");
        model(c, r, a);
        rd(`PKES_ADDR_STATUS, exp_status, 1'b0);
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset_map;
        rd(`PKES_ADDR_STATUS, `PKES_STATUS_RESET, 1'b0);
        rd(`PKES_ADDR_VERSION, {16'h0000, HW_REV, 8'h00}, 1'b0);
        rd(`PKES_ADDR_LAUNCH, 32'h0000_0000, 1'b0);
        rd(32'h5000_6020, 32'h0000_0000, 1'b1);
        wr(32'h5000_6020, 32'hFFFF_FFFF, 1'b1);
        wr(`PKES_ADDR_STATUS, 32'hFFFF_FFFF, 1'b0);
        wr(`PKES_ADDR_VERSION, 32'hFFFF_FFFF, 1'b0);
        rd(`PKES_ADDR_STATUS, `PKES_STATUS_RESET, 1'b0);
        rd(`PKES_ADDR_VERSION, {16'h0000, HW_REV, 8'h00}, 1'b0);
        $display("test reset_map done");
    endtask

    task automatic t_fw_rev;
        @(posedge pclk);
        fw_rev_we   <= 1'b1;
        fw_rev_data <= 8'hA5;
        @(posedge pclk);
        fw_rev_we   <= 1'b0;
        fw_rev_data <= 8'h3C;
        rd(`PKES_ADDR_VERSION, {16'h0000, HW_REV, 8'hA5}, 1'b0);
        $display("test fw_rev done");
    endtask

    task automatic t_busy_guard;
        wr(`PKES_ADDR_LAUNCH, {17'h0_0000, `PKES_OPC_CURVE_COEFF_CHECK_CMD, 8'h01}, 1'b0);
        rd(`PKES_ADDR_STATUS, exp_status | 32'h0001_0000, 1'b0);
        rd(`PKES_ADDR_LAUNCH, {17'h0_0000, `PKES_OPC_CURVE_COEFF_CHECK_CMD, 8'h01}, 1'b0);
        wr(`PKES_ADDR_LAUNCH, {17'h0_0000, `PKES_OPC_PRIMALITY, 8'h01}, 1'b0);
        #1;
        chk1(launch_pulse, 1'b0, "launch while busy");
        check({25'h0, operation_code_field}, {25'h0, `PKES_OPC_CURVE_COEFF_CHECK_CMD}, "code");
        finish(8'h20, 4'h8);
        chk1(busy, 1'b0, "busy low");
        model(`PKES_OPC_CURVE_COEFF_CHECK_CMD, 8'h20, 4'h8);
        rd(`PKES_ADDR_LAUNCH, {17'h0_0000, `PKES_OPC_CURVE_COEFF_CHECK_CMD, 8'h00}, 1'b0);
        rd(`PKES_ADDR_STATUS, exp_status, 1'b0);
        // Completion while idle must leave every flag alone
        finish(8'hFF, 4'hF);
        rd(`PKES_ADDR_STATUS, exp_status, 1'b0);
        $display("test busy_guard done");
    endtask

    task automatic t_results;
        run_op(`PKES_OPC_PRIMALITY, 8'hFF, 4'h3);
        run_op(`PKES_OPC_PRIMALITY, 8'h00, 4'h3);
        run_op(7'h06, 8'h40, 4'h1);
        run_op(7'h09, 8'h00, 4'h1);
        run_op(7'h09, 8'h40, 4'h2);
        run_op(7'h16, 8'h00, 4'h2);
        run_op(`PKES_OPC_CURVE_COEFF_CHECK_CMD, 8'h00, 4'h4);
        for (int i = 4; i < 8; i++) begin
            run_op({`PKES_SIG_PREFIX, i[1:0]}, {3'h0, i[0], 4'h0}, 4'h6);
        end
        run_op(`PKES_OPC_CHECK_N, 8'h08, 4'h2);
        run_op(`PKES_OPC_COUPLE, 8'h04, 4'h9);
        run_op(`PKES_OPC_ON_CURVE, 8'h01, 4'h5);
        run_op(7'h20, 8'h02, 4'hC);
        run_op(7'h01, 8'h02, 4'h7);
        run_op(`PKES_OPC_ON_CURVE, 8'h00, 4'hA);
        $display("test results done");
    endtask

    task automatic t_rereset;
        wr(`PKES_ADDR_LAUNCH, {17'h0_0000, 7'h20, 8'h01}, 1'b0);
        @(posedge pclk);
        presetn <= 1'b0;
        #1;
        chk1(busy, 1'b0, "busy in reset");
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        exp_status = `PKES_STATUS_RESET;
        rd(`PKES_ADDR_STATUS, exp_status, 1'b0);
        rd(`PKES_ADDR_VERSION, {16'h0000, HW_REV, 8'h00}, 1'b0);
        $display("test rereset done");
    endtask

    task automatic report_and_stop;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ==========================================================
    // Clock, watchdog, sequence
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // Whole run is a few hundred cycles; this is far beyond it
    initial begin
        #200000;
        failures++;
        $display("[ERR] %0t ns: watchdog expired", $time);
        report_and_stop();
    end

    initial begin
        presetn       = 1'b0;
        psel          = 1'b0;
        penable       = 1'b0;
        pwrite        = 1'b0;
        paddr         = 32'h0000_0000;
        pwdata        = 32'h0000_0000;
        op_done       = 1'b0;
        res           = 8'h00;
        res_fail_addr = 4'h0;
        fw_rev_we     = 1'b0;
        fw_rev_data   = 8'h00;
        exp_status    = `PKES_STATUS_RESET;
        failures      = 0;
        checks_done   = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_map();
        t_fw_rev();
        t_busy_guard();
        t_results();
        t_rereset();
        report_and_stop();
    end
endmodule
`default_nettype wire
